// ===== tb/mci_host_model.sv
// host terminal model that issues monitor-mode commands
`timescale 1ns/100ps
module mci_host_model (
    input  wire logic       clk,
    output logic            cmdValid,
    output logic [2:0]      cmdCode,
    output logic [7:0]      cmdIndex,
    output logic [7:0]      cmdOperand,
    input  wire logic       cmdAck,
    input  wire logic       cmdReject
);
    initial begin
        cmdValid = 1'b0;
        cmdCode = 3'h0;
        cmdIndex = 8'h00;
        cmdOperand = 8'h00;
    end

    // operands as commanded
    // program names arrive already mapped to an 8-bit id, so never too long;
    // out-of-range operands are sent only when the caller wants a refusal
    task automatic send(input logic [2:0] code, input logic [7:0] idx,
                        input logic [7:0] op, output logic [1:0] resp);
        @(negedge clk);
        cmdValid = 1'b1;
        cmdCode = code;
        cmdIndex = idx;
        cmdOperand = op;
        @(negedge clk);
        resp = {cmdAck, cmdReject};
        cmdValid = 1'b0;
        // scrambled after release so nothing leans on stale fields
        cmdCode = ~code;
        cmdIndex = ~idx;
        cmdOperand = ~op;
    endtask
endmodule

// ===== tb/tb_monitor_command_io_control.sv
// self-checking bench for the monitor-mode command handler
`timescale 1ns/100ps
module tb_monitor_command_io_control;
    typedef struct packed {
        logic [2:0] code;
        logic [7:0] idx;
        logic [7:0] op;
        logic [1:0] resp;
        logic       motor;
        logic [7:0] outs;
    } mci_row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        seqDone = 1'b0;
    logic        funcAssignSet = 1'b0;
    logic        alarmClear = 1'b0;
    logic [13:0] pins = 14'h0000;
    logic [7:0]  genIn;
    logic        cmdValid, cmdAck, cmdReject, reportValid;
    logic [2:0]  cmdCode;
    logic [7:0]  cmdIndex, cmdOperand, general_outputs, runProgId;
    logic [13:0] inputReport;
    logic        motorCurrentOn, funcAssignActive, paramInit, varClear;
    logic        runStart, seqMode, alarm;
    logic [1:0]  resp;
    int          badCount = 0;
    int          cmpCount = 0;
    logic [2:0]  cancelCodes [3] = '{3'h2, 3'h4, 3'h5};
    logic [13:0] pats [3] = '{14'h0240, 14'h2D01, 14'h0100};
    mci_row_t    rows [12] = '{
        '{3'h1, 8'h00, 8'h00, 2'h2, 1'b1, 8'h00},
        '{3'h4, 8'h00, 8'h21, 2'h2, 1'b1, 8'h21},
        '{3'h5, 8'h07, 8'h01, 2'h2, 1'b1, 8'hA1},
        '{3'h5, 8'h00, 8'h00, 2'h2, 1'b1, 8'hA0},
        '{3'h5, 8'h08, 8'h01, 2'h1, 1'b1, 8'hA0},
        '{3'h5, 8'h03, 8'h02, 2'h1, 1'b1, 8'hA0},
        '{3'h7, 8'h00, 8'hFF, 2'h1, 1'b1, 8'hA0},
        '{3'h2, 8'h00, 8'h00, 2'h2, 1'b1, 8'hA0},
        '{3'h4, 8'h00, 8'hFF, 2'h2, 1'b1, 8'hFF},
        '{3'h3, 8'h00, 8'h00, 2'h2, 1'b1, 8'hFF},
        '{3'h4, 8'h00, 8'h00, 2'h2, 1'b1, 8'h00},
        '{3'h0, 8'h00, 8'h00, 2'h2, 1'b0, 8'h00}
    };

    assign genIn = {<<{pins[7:0]}};
    always #10 clk = ~clk;

    mci_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdIndex(cmdIndex), .cmdOperand(cmdOperand), .cmdAck(cmdAck),
        .cmdReject(cmdReject));

    mci_monitor_io_control uut (.clk(clk), .rst(rst), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdIndex(cmdIndex), .cmdOperand(cmdOperand),
        .seqDone(seqDone), .funcAssignSet(funcAssignSet),
        .alarmClear(alarmClear), .eStopIn(pins[13]), .startIn(pins[12]),
        .home_aux_input_a_input(pins[11]), .aux_input_a(pins[10]),
        .positive_limit_input(pins[9]), .negative_limit_input(pins[8]),
        .general_inputs(genIn), .cmdAck(cmdAck), .cmdReject(cmdReject),
        .reportValid(reportValid), .inputReport(inputReport),
        .motorCurrentOn(motorCurrentOn), .general_outputs(general_outputs),
        .funcAssignActive(funcAssignActive), .paramInit(paramInit),
        .varClear(varClear), .runStart(runStart), .runProgId(runProgId),
        .seqMode(seqMode), .alarm(alarm));

    task automatic chk(input string name, input logic [15:0] exp, got);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic giveVerdict();
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic assignFunc();
        @(negedge clk);
        funcAssignSet = 1'b1;
        @(negedge clk);
        funcAssignSet = 1'b0;
        chk("funcSet", 16'h1, 16'(funcAssignActive));
    endtask

    // the start pin passes two sync flops, so the launch lags a few cycles
    task automatic waitRun();
        int n;
        n = 0;
        while (runStart !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (runStart !== 1'b1) begin
            badCount++;
            $display("[FAIL] runStart expected 1 seen none");
        end
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk("reset", 16'h0, {5'h00, seqMode, alarm, motorCurrentOn,
            general_outputs});
        foreach (rows[i]) begin
            host.send(rows[i].code, rows[i].idx, rows[i].op, resp);
            chk("resp", 16'(rows[i].resp), 16'(resp));
            chk("motor", 16'(rows[i].motor), 16'(motorCurrentOn));
            chk("outs", 16'(rows[i].outs), 16'(general_outputs));
            chk("pinit", 16'(rows[i].code == 3'h3), 16'(paramInit));
        end
        foreach (cancelCodes[k]) begin
            assignFunc();
            host.send(cancelCodes[k], 8'h00, 8'h00, resp);
            chk("funcCancel", 16'h0, 16'(funcAssignActive));
        end
        assignFunc();
        host.send(3'h5, 8'h09, 8'h00, resp);
        chk("funcKeep", 16'h1, 16'(funcAssignActive));
        foreach (pats[j]) begin
            @(negedge clk);
            pins = pats[j];
            repeat (4) @(negedge clk);
            host.send(3'h2, 8'h00, 8'h00, resp);
            chk("rvalid", 16'h1, 16'(reportValid));
            chk("report", 16'(pats[j]), 16'(inputReport));
            chk("alarm", 16'h1, 16'(alarm));
        end
        pins = 14'h0000;
        repeat (4) @(negedge clk);
        alarmClear = 1'b1;
        @(negedge clk);
        alarmClear = 1'b0;
        @(negedge clk);
        chk("alarmClr", 16'h0, 16'(alarm));
        assignFunc();
        host.send(3'h6, 8'h00, 8'h5A, resp);
        chk("runPulse", 16'h3, 16'({runStart, varClear}));
        chk("runProg", 16'h15A, 16'({seqMode, runProgId}));
        chk("runCancel", 16'h0, 16'(funcAssignActive));
        host.send(3'h1, 8'h00, 8'h00, resp);
        chk("seqRefuse", 16'h2, {13'h0000, resp, motorCurrentOn});
        @(negedge clk);
        seqDone = 1'b1;
        @(negedge clk);
        seqDone = 1'b0;
        chk("seqExit", 16'h0, 16'(seqMode));
        pins[12] = 1'b1;
        waitRun();
        chk("startRun", {7'h01, mci_pkg::STARTUP_PROG, 1'b1},
            {7'(seqMode), runProgId, varClear});
        giveVerdict();
    end
endmodule

// ===== verilog/mci_monitor_io_control.sv
// monitor-mode command handler for motor current, general i/o and run
`timescale 1ns/100ps
module mci_monitor_io_control (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         cmdValid,
    input  wire logic [2:0]                   cmdCode,
    input  wire logic [7:0]                   cmdIndex,
    input  wire logic [7:0]                   cmdOperand,
    input  wire logic                         seqDone,
    input  wire logic                         funcAssignSet,
    input  wire logic                         alarmClear,
    input  wire logic                         eStopIn,
    input  wire logic                         startIn,
    input  wire logic                         home_aux_input_a_input,
    input  wire logic                         aux_input_a,
    input  wire logic                         positive_limit_input,
    input  wire logic                         negative_limit_input,
    input  wire logic [mci_pkg::GEN_W-1:0]    general_inputs,
    output logic                              cmdAck,
    output logic                              cmdReject,
    output logic                              reportValid,
    output logic [mci_pkg::REPORT_W-1:0]      inputReport,
    output logic                              motorCurrentOn,
    output logic [mci_pkg::GEN_W-1:0]         general_outputs,
    output logic                              funcAssignActive,
    output logic                              paramInit,
    output logic                              varClear,
    output logic                              runStart,
    output logic [7:0]                        runProgId,
    output logic                              seqMode,
    output logic                              alarm
);

    function automatic logic isPortCmd(input logic [2:0] code);
        isPortCmd = (code == 3'(mci_pkg::CMD_INPUT_MON)) ||
                    (code == 3'(mci_pkg::CMD_OUT_ALL)) ||
                    (code == 3'(mci_pkg::CMD_OUT_ONE));
    endfunction

    logic [mci_pkg::REPORT_W-1:0] pinRaw;
    logic [mci_pkg::REPORT_W-1:0] pinSync1_q;
    logic [mci_pkg::REPORT_W-1:0] pinSync2_q;
    logic                         startPrev_q;
    mci_pkg::mode_t               mode_q;
    mci_pkg::mode_t               mode_d;
    logic                         ack_q;
    logic                         ack_d;
    logic                         reject_q;
    logic                         reject_d;
    logic                         rptValid_q;
    logic                         rptValid_d;
    logic [mci_pkg::REPORT_W-1:0] report_q;
    logic [mci_pkg::REPORT_W-1:0] report_d;
    logic                         motor_q;
    logic                         motor_d;
    logic [mci_pkg::GEN_W-1:0]    outs_q;
    logic [mci_pkg::GEN_W-1:0]    outs_d;
    logic                         assign_q;
    logic                         assign_d;
    logic                         param_q;
    logic                         param_d;
    logic                         varClr_q;
    logic                         varClr_d;
    logic                         run_q;
    logic                         run_d;
    logic [7:0]                   progId_q;
    logic [7:0]                   progId_d;
    logic                         alarm_q;
    logic                         alarm_d;
    logic                         monitorMode;
    logic                         startEdge;
    logic                         alarmCause;
    logic                         cmdTake;
    logic                         cmdGood;

    // report order, msb first
    // report order
    assign pinRaw = {eStopIn, startIn, home_aux_input_a_input, aux_input_a,
                     positive_limit_input, negative_limit_input,
                     general_inputs[0], general_inputs[1],
                     general_inputs[2], general_inputs[3],
                     general_inputs[4], general_inputs[5],
                     general_inputs[6], general_inputs[7]};

    // pins are asynchronous, so two flops before any use
    always_ff @(posedge clk) begin
        if (rst) begin
            pinSync1_q  <= '0;
            pinSync2_q  <= '0;
            startPrev_q <= 1'b0;
        end else begin
            pinSync1_q  <= pinRaw;
            pinSync2_q  <= pinSync1_q;
            startPrev_q <= pinSync2_q[mci_pkg::RPT_START];
        end
    end

    assign monitorMode = (mode_q == mci_pkg::MODE_MONITOR);
    assign startEdge   = pinSync2_q[mci_pkg::RPT_START] && !startPrev_q;
    assign alarmCause  = pinSync2_q[mci_pkg::RPT_ESTOP] ||
                         pinSync2_q[mci_pkg::RPT_POS_LIMIT] ||
                         pinSync2_q[mci_pkg::RPT_NEG_LIMIT];
    assign cmdTake     = cmdValid && monitorMode;

    always_comb begin
        mode_d     = mode_q;
        ack_d      = 1'b0;
        reject_d   = 1'b0;
        rptValid_d = 1'b0;
        report_d   = report_q;
        motor_d    = motor_q;
        outs_d     = outs_q;
        assign_d   = assign_q;
        param_d    = 1'b0;
        varClr_d   = 1'b0;
        run_d      = 1'b0;
        progId_d   = progId_q;
        cmdGood    = 1'b0;
        if (cmdTake) begin
            unique case (mci_pkg::cmd_t'(cmdCode))
                mci_pkg::CMD_CURRENT_OFF: begin
                    motor_d = 1'b0;
                    cmdGood = 1'b1;
                end
                mci_pkg::CMD_CURRENT_ON: begin
                    motor_d = 1'b1;
                    cmdGood = 1'b1;
                end
                mci_pkg::CMD_INPUT_MON: begin
                    rptValid_d = 1'b1;
                    report_d   = pinSync2_q;
                    cmdGood    = 1'b1;
                end
                mci_pkg::CMD_PARAM_INIT: begin
                    param_d = 1'b1;
                    cmdGood = 1'b1;
                end
                mci_pkg::CMD_OUT_ALL: begin
                    outs_d  = cmdOperand;
                    cmdGood = 1'b1;
                end
                mci_pkg::CMD_OUT_ONE: begin
                    if (cmdIndex <= mci_pkg::PORT_IDX_MAX &&
                        cmdOperand <= mci_pkg::PORT_VAL_MAX) begin
                        outs_d[cmdIndex[2:0]] = cmdOperand[0];
                        cmdGood = 1'b1;
                    end
                end
                mci_pkg::CMD_RUN: begin
                    mode_d   = mci_pkg::MODE_SEQUENCE;
                    run_d    = 1'b1;
                    progId_d = cmdOperand;
                    cmdGood  = 1'b1;
                end
                default: cmdGood = 1'b0;
            endcase
            ack_d    = cmdGood;
            reject_d = !cmdGood;
        end else if (cmdValid) begin
            reject_d = 1'b1;
        end
        if (monitorMode && !cmdValid && startEdge) begin
            mode_d   = mci_pkg::MODE_SEQUENCE;
            run_d    = 1'b1;
            progId_d = mci_pkg::STARTUP_PROG;
        end
        varClr_d = run_d;
        if ((cmdGood && isPortCmd(cmdCode)) || run_d) begin
            assign_d = 1'b0;
        end
        // a new assignment in the same cycle survives the cancel
        if (funcAssignSet) begin
            assign_d = 1'b1;
        end
        if (!monitorMode && seqDone) begin
            mode_d = mci_pkg::MODE_MONITOR;
        end
        // alarm in monitor mode, set beats clear
        alarm_d = alarm_q;
        if (alarmClear) begin
            alarm_d = 1'b0;
        end
        if (monitorMode && alarmCause) begin
            alarm_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q     <= mci_pkg::MODE_MONITOR;
            ack_q      <= 1'b0;
            reject_q   <= 1'b0;
            rptValid_q <= 1'b0;
            report_q   <= '0;
            motor_q    <= mci_pkg::MOTOR_RESET;
            outs_q     <= mci_pkg::OUT_RESET;
            assign_q   <= 1'b0;
            param_q    <= 1'b0;
            varClr_q   <= 1'b0;
            run_q      <= 1'b0;
            progId_q   <= mci_pkg::STARTUP_PROG;
            alarm_q    <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            ack_q      <= ack_d;
            reject_q   <= reject_d;
            rptValid_q <= rptValid_d;
            report_q   <= report_d;
            motor_q    <= motor_d;
            outs_q     <= outs_d;
            assign_q   <= assign_d;
            param_q    <= param_d;
            varClr_q   <= varClr_d;
            run_q      <= run_d;
            progId_q   <= progId_d;
            alarm_q    <= alarm_d;
        end
    end

    // no inversion on any port path
    assign cmdAck           = ack_q;
    assign cmdReject        = reject_q;
    assign reportValid      = rptValid_q;
    assign inputReport      = report_q;
    assign motorCurrentOn   = motor_q;
    assign general_outputs  = outs_q;
    assign funcAssignActive = assign_q;
    assign paramInit        = param_q;
    assign varClear         = varClr_q;
    assign runStart         = run_q;
    assign runProgId        = progId_q;
    assign seqMode          = logic'(mode_q);
    assign alarm            = alarm_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence taken(logic [2:0] c);
        cmdValid && monitorMode && cmdCode == c;
    endsequence

    sequence runLaunch;
        runStart && varClear ##0 seqMode;
    endsequence

    curr_off_a: assert property (
        taken(3'(mci_pkg::CMD_CURRENT_OFF)) |=> !motorCurrentOn && cmdAck)
        else $error("motor current still on after off command");
    curr_on_a: assert property (
        taken(3'(mci_pkg::CMD_CURRENT_ON)) |=> motorCurrentOn && cmdAck)
        else $error("motor current not on after on command");
    in_report_a: assert property (
        taken(3'(mci_pkg::CMD_INPUT_MON))
        |=> reportValid && inputReport == $past(pinSync2_q))
        else $error("input report does not match synced pins");
    report_order_a: assert property (
        taken(3'(mci_pkg::CMD_INPUT_MON)) |=> reportValid &&
        inputReport[mci_pkg::RPT_ESTOP] == $past(eStopIn, 3) &&
        inputReport[mci_pkg::GEN_W-1] == $past(general_inputs[0], 3))
        else $error("report order does not match the input pins");
    out_all_a: assert property (
        taken(3'(mci_pkg::CMD_OUT_ALL))
        |=> general_outputs == $past(cmdOperand))
        else $error("all-port output not applied");
    out_one_a: assert property (
        taken(3'(mci_pkg::CMD_OUT_ONE)) &&
        cmdIndex <= mci_pkg::PORT_IDX_MAX &&
        cmdOperand <= mci_pkg::PORT_VAL_MAX
        |=> general_outputs[$past(cmdIndex[2:0])] == $past(cmdOperand[0]))
        else $error("single-port output not applied");
    port_cancel_a: assert property (
        taken(3'(mci_pkg::CMD_OUT_ALL)) && !funcAssignSet
        |=> !funcAssignActive)
        else $error("port assignment survived a port command");
    param_init_a: assert property (
        taken(3'(mci_pkg::CMD_PARAM_INIT)) |=> paramInit ##1
        (!paramInit ||
         $past(cmdTake && cmdCode == 3'(mci_pkg::CMD_PARAM_INIT))))
        else $error("parameter init not a single pulse");
    run_cmd_a: assert property (
        taken(3'(mci_pkg::CMD_RUN))
        |=> runLaunch ##0 runProgId == $past(cmdOperand))
        else $error("run command did not start the program");
    start_pin_a: assert property (
        monitorMode && !cmdValid && startEdge
        |=> runLaunch ##0 runProgId == mci_pkg::STARTUP_PROG)
        else $error("start input did not launch startup program");
    alarm_set_a: assert property (
        monitorMode && alarmCause |=> alarm)
        else $error("alarm not raised by stop or limit input");
    var_clear_a: assert property (
        runStart |-> varClear && (!funcAssignActive || $past(funcAssignSet)))
        else $error("program start did not clear state");
    seq_reject_a: assert property (
        cmdValid && !monitorMode
        |=> cmdReject && !cmdAck && $stable(general_outputs))
        else $error("command accepted outside monitor mode");
    no_polarity_a: assert property (
        reportValid |-> inputReport == $past(pinRaw, 3))
        else $error("report shows altered input polarity");
endmodule

// ===== verilog/mci_pkg.sv
// constants and types for the monitor-mode command and i/o controller
package mci_pkg;
    typedef enum logic [2:0] {
        CMD_CURRENT_OFF,
        CMD_CURRENT_ON,
        CMD_INPUT_MON,
        CMD_PARAM_INIT,
        CMD_OUT_ALL,
        CMD_OUT_ONE,
        CMD_RUN
    } cmd_t;
    typedef enum logic {
        MODE_MONITOR,
        MODE_SEQUENCE
    } mode_t;
    localparam int          GEN_W          = 8;
    localparam int          REPORT_W       = 14;
    // report bit positions, leftmost (msb) first
    localparam int          RPT_ESTOP      = 13;
    localparam int          RPT_START      = 12;
    localparam int          RPT_HOME       = 11;
    localparam int          RPT_AUX        = 10;
    localparam int          RPT_POS_LIMIT  = 9;
    localparam int          RPT_NEG_LIMIT  = 8;
    localparam logic [7:0]  PORT_IDX_MAX   = 8'h07;
    localparam logic [7:0]  PORT_VAL_MAX   = 8'h01;
    localparam logic [7:0]  STARTUP_PROG   = 8'h00;
    localparam logic [7:0]  OUT_RESET      = 8'h00;
    localparam logic        MOTOR_RESET    = 1'b0;
endpackage
